// ---- dmam_addr_unit.v ----
// One 24-bit auto-stepping DMA address register with byte-wide software access
`default_nettype none
`include "dmam_regs.vh"

module dmam_addr_unit (
    // Clock and reset
    input  wire                      clk_i,
    input  wire                      rst_i,
    // Software byte writes
    input  wire [2:0]                wr_byte_i,
    input  wire [7:0]                wr_data_i,
    // Stepping
    input  wire [1:0]                dir_i,
    input  wire                      step_i,
    // State
    output reg  [`DMAM_ADDR_W-1:0]   addr_o,
    output reg                       wrap_o
);

    reg [`DMAM_ADDR_W-1:0] next_addr;
    reg                    next_wrap;

    // ======================================================================
    // Next address
    // ======================================================================
    always @* begin
        next_addr = addr_o;
        next_wrap = 1'b0;
        if (|wr_byte_i) begin
            // A software write beats a step in the same cycle [RL7]
            if (wr_byte_i[0]) next_addr[7:0]   = wr_data_i;
            if (wr_byte_i[1]) next_addr[15:8]  = wr_data_i;
            if (wr_byte_i[2]) next_addr[23:16] = wr_data_i;
        end else if (step_i) begin
            case (dir_i)
                `DMAM_DIR_INC: begin
                    next_addr = addr_o + 24'h000001; // [RL9]
                    next_wrap = &addr_o;
                end
                `DMAM_DIR_DEC: begin
                    next_addr = addr_o - 24'h000001; // [RL9]
                    next_wrap = ~|addr_o;
                end
                default: begin
                    next_addr = addr_o;
                end
            endcase
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            addr_o <= `DMAM_RST_ADDR;
            wrap_o <= 1'b0;
        end else begin
            addr_o <= next_addr;
            wrap_o <= next_wrap;
        end
    end

endmodule // dmam_addr_unit
`default_nettype wire

// ---- dmam_asserts.sv ----
// Concurrent checks on the ports of the DMA address map core
`default_nettype none
// ==========================================================================
// Checker
// ==========================================================================
module dmam_asserts (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Wishbone slave
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [8:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Transfer side
    input wire logic [3:0]  byte_moved_i,
    input wire logic [95:0] source_address_o,
    input wire logic [95:0] destination_address_o,
    // Interrupt
    input wire logic        irq_o,
    input wire logic [7:0]  irq_vector_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire logic       req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic [3:0] slot = wb_adr_i[5:2];
    wire logic       in_ch = (wb_adr_i[8:2] >= 7'h10) && (wb_adr_i[8:2] <= 7'h4F);

    AST_ACK_NEXT: assert property (req |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_IDLE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    AST_RSVD_ZERO: assert property (req && !wb_we_i && in_ch &&
        (slot == 4'h7 || slot == 4'hB || slot == 4'hF) |=> wb_dat_o == 32'h0)
        else $error("reserved slot reads nonzero");
    AST_UPPER_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read data bits set");
    AST_SRC_STEP: assert property (byte_moved_i[0] && !wb_cyc_i ##1 !wb_cyc_i |=>
        24'(source_address_o[23:0] - $past(source_address_o[23:0]))
        inside {24'h000000, 24'h000001, 24'hFFFFFF})
        else $error("source address moved by more than one");
    AST_DST_STEP: assert property (byte_moved_i[0] && !wb_cyc_i ##1 !wb_cyc_i |=>
        24'(destination_address_o[23:0] - $past(destination_address_o[23:0]))
        inside {24'h000000, 24'h000001, 24'hFFFFFF})
        else $error("destination address moved by more than one");
    AST_HOLD: assert property ((byte_moved_i == 4'h0 && !wb_cyc_i)[*2] |=>
        $stable(source_address_o) && $stable(destination_address_o))
        else $error("address changed without step or write");
    AST_VEC_IDLE: assert property (!irq_o |-> irq_vector_o == 8'h00)
        else $error("vector nonzero without interrupt");
    AST_VEC_SET: assert property (irq_o |->
        irq_vector_o inside {8'h00, 8'h02, 8'h04, 8'h06})
        else $error("vector outside channel offsets");
endmodule // dmam_asserts

bind dmam_core dmam_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .byte_moved_i(byte_moved_i),
    .source_address_o(source_address_o), .destination_address_o(destination_address_o),
    .irq_o(irq_o), .irq_vector_o(irq_vector_o));
`default_nettype wire

// ---- dmam_core.v ----
// Four-channel DMA address registers, register map and interrupt vectoring
// Function
// RL1 - Each channel holds a 24-bit destination address over three bytes, low to high.
// RL2 - Destination address steps up, down or holds per destination-direction field.
// RL3 - Source address bytes sit at channel offsets 0x08-0x0A; 0x0A is bits 23:16.
// RL4 - Destination bytes at 0x0C-0x0E low to high; 0x07, 0x0B, 0x0F reserved.
// RL5 - Channel blocks 0 to 3 at controller offsets 0x10, 0x20, 0x30, 0x40.
// RL6 - One interrupt vector per channel at word offsets 0x00, 0x02, 0x04, 0x06.
// RL7 - Software uses the multi-byte procedure to access the 24-bit addresses coherently; here each byte is read and written live, with no temporary register.
// RL8 - Source address steps up, down or holds per source-direction field.
// RL9 - A stepping address moves by one per byte moved, carrying over all 24 bits.
//
// Our own choice: the Wishbone interface to the registers.
`default_nettype none
`include "dmam_regs.vh"

module dmam_core (
    // Clock and reset
    input  wire                  clk_i,
    input  wire                  rst_i,
    // Wishbone slave
    input  wire                  wb_cyc_i,
    input  wire                  wb_stb_i,
    input  wire                  wb_we_i,
    input  wire [8:0]            wb_adr_i,
    input  wire [3:0]            wb_sel_i,
    input  wire [31:0]           wb_dat_i,
    output reg  [31:0]           wb_dat_o,
    output reg                   wb_ack_o,
    // Transfer side: one pulse per byte moved, per channel
    input  wire [3:0]            byte_moved_i,
    output reg  [95:0]           source_address_o,
    output reg  [95:0]           destination_address_o,
    // Interrupt
    output reg                   irq_o,
    output reg  [7:0]            irq_vector_o
);

    // ======================================================================
    // Storage
    // ======================================================================
    // Controller registers
    reg  [7:0]  ctrl;
    reg  [7:0]  evt_status;
    reg  [7:0]  evt_mask;

    // Per-channel registers; only address control acts in this block
    reg  [7:0]  ctrl_a     [0:3];
    reg  [7:0]  ctrl_b     [0:3];
    reg  [7:0]  addr_ctrl  [0:3];
    reg  [7:0]  trig_sel   [0:3];

    // Counts are only stored; the sequencer outside counts them down
    reg  [7:0]  cnt_low    [0:3];
    reg  [7:0]  cnt_high   [0:3];
    reg  [7:0]  rep_cnt    [0:3];

    // Live addresses, channel n in bits 24n+23 down to 24n
    wire [95:0] src_addr;
    wire [95:0] dst_addr;

    // Wrap pulses, one cycle after the wrapping step
    wire [3:0]  src_wrap;
    wire [3:0]  dst_wrap;

    reg  [31:0] rd_data;

    reg  [7:0]  next_status;
    reg  [7:0]  next_vector;
    reg  [7:0]  pending;

    integer     i;

    // ======================================================================
    // Address decode
    // ======================================================================
    // Register index; address bits 1:0 are ignored
    wire [`DMAM_IDX_W-1:0] idx      = wb_adr_i[8:2];
    wire [3:0]             ch_off   = idx[3:0];
    wire                   in_ch    = (idx >= `DMAM_IDX_CH0_BASE) &&
                                      (idx <  (`DMAM_IDX_CH3_BASE + `DMAM_IDX_CH_SPAN)); // [RL5]
    wire [1:0]             ch_sel   = idx[5:4] - 2'h1; // [RL5]

    wire                   req      = wb_cyc_i & wb_stb_i;

    // Writes land on the edge where the master sees ack
    wire                   wr_take  = req & wb_ack_o & wb_we_i & wb_sel_i[0];

    // ======================================================================
    // Address units, one source and one destination per channel
    // ======================================================================
    genvar g;
    generate
        for (g = 0; g < `DMAM_NUM_CH; g = g + 1) begin : g_ch
            // Each channel block decodes its own address bytes
            wire       hit = wr_take & in_ch & (ch_sel == g);
            wire [2:0] src_wr;
            wire [2:0] dst_wr;
            assign src_wr[0] = hit & (ch_off == `DMAM_CH_SRC_B0); // [RL3]
            assign src_wr[1] = hit & (ch_off == `DMAM_CH_SRC_B1); // [RL3]
            assign src_wr[2] = hit & (ch_off == `DMAM_CH_SRC_B2); // [RL3]

            assign dst_wr[0] = hit & (ch_off == `DMAM_CH_DST_B0); // [RL4]
            assign dst_wr[1] = hit & (ch_off == `DMAM_CH_DST_B1); // [RL4]
            assign dst_wr[2] = hit & (ch_off == `DMAM_CH_DST_B2); // [RL4]

            // A bus write wins over a step landing in the same cycle
            dmam_addr_unit u_src (
                .clk_i     (clk_i),
                .rst_i     (rst_i),
                .wr_byte_i (src_wr),
                .wr_data_i (wb_dat_i[7:0]),
                .dir_i     (addr_ctrl[g][`DMAM_SRC_DIR_HI:`DMAM_SRC_DIR_LO]), // [RL8]
                .step_i    (byte_moved_i[g]),
                .addr_o    (src_addr[g*24 +: 24]),
                .wrap_o    (src_wrap[g])
            );

            dmam_addr_unit u_dst (
                .clk_i     (clk_i),
                .rst_i     (rst_i),
                .wr_byte_i (dst_wr),
                .wr_data_i (wb_dat_i[7:0]),
                .dir_i     (addr_ctrl[g][`DMAM_DST_DIR_HI:`DMAM_DST_DIR_LO]), // [RL2]
                .step_i    (byte_moved_i[g]),
                .addr_o    (dst_addr[g*24 +: 24]),                            // [RL1]
                .wrap_o    (dst_wrap[g])
            );
        end
    endgenerate

    // ======================================================================
    // Read mux
    // ======================================================================
    always @* begin
        rd_data = 32'h00000000;
        if (in_ch) begin
            case (ch_off)
                // Configuration and counts
                `DMAM_CH_CTRL_A:    rd_data[7:0] = ctrl_a[ch_sel];
                `DMAM_CH_CTRL_B:    rd_data[7:0] = ctrl_b[ch_sel];
                `DMAM_CH_ADDR_CTRL: rd_data[7:0] = addr_ctrl[ch_sel];
                `DMAM_CH_TRIG_SEL:  rd_data[7:0] = trig_sel[ch_sel];
                `DMAM_CH_CNT_LOW:   rd_data[7:0] = cnt_low[ch_sel];
                `DMAM_CH_CNT_HIGH:  rd_data[7:0] = cnt_high[ch_sel];
                `DMAM_CH_REPEAT:    rd_data[7:0] = rep_cnt[ch_sel];

                // Source address, low byte first
                `DMAM_CH_SRC_B0:    rd_data[7:0] = src_addr[ch_sel*24 +: 8];      // [RL3]
                `DMAM_CH_SRC_B1:    rd_data[7:0] = src_addr[ch_sel*24 + 8 +: 8];  // [RL3]
                `DMAM_CH_SRC_B2:    rd_data[7:0] = src_addr[ch_sel*24 + 16 +: 8]; // [RL3]

                // Destination address, low byte first
                `DMAM_CH_DST_B0:    rd_data[7:0] = dst_addr[ch_sel*24 +: 8];      // [RL1]
                `DMAM_CH_DST_B1:    rd_data[7:0] = dst_addr[ch_sel*24 + 8 +: 8];  // [RL1]
                `DMAM_CH_DST_B2:    rd_data[7:0] = dst_addr[ch_sel*24 + 16 +: 8]; // [RL1]

                // Reserved slots read as zero and ignore writes
                default:            rd_data = 32'h00000000; // [RL4]
            endcase
        end else begin
            // Controller registers outside the channel blocks
            case (idx)
                `DMAM_IDX_CTRL:       rd_data[7:0] = ctrl;
                `DMAM_IDX_EVT_STATUS: rd_data[7:0] = evt_status;
                `DMAM_IDX_EVT_MASK:   rd_data[7:0] = evt_mask;
                default:              rd_data = 32'h00000000;
            endcase
        end
    end

    // ======================================================================
    // Bus handshake: ack one cycle after the request, dropped after one
    // ======================================================================
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            // A strobe still high after ack does not start a second cycle
            wb_ack_o <= req & ~wb_ack_o;

            // Data is latched once, so it stands unchanged beside ack
            if (req & ~wb_ack_o) begin
                wb_dat_o <= rd_data;
            end
        end
    end

    // ======================================================================
    // Plain registers
    // ======================================================================
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl     <= `DMAM_RST_BYTE;
            evt_mask <= `DMAM_RST_BYTE;

            for (i = 0; i < `DMAM_NUM_CH; i = i + 1) begin
                ctrl_a[i]    <= `DMAM_RST_BYTE;
                ctrl_b[i]    <= `DMAM_RST_BYTE;
                addr_ctrl[i] <= `DMAM_RST_BYTE;
                trig_sel[i]  <= `DMAM_RST_BYTE;
                cnt_low[i]   <= `DMAM_RST_CNT;
                cnt_high[i]  <= `DMAM_RST_CNT;
                rep_cnt[i]   <= `DMAM_RST_BYTE;
            end
        // Address bytes are written inside the address units
        end else if (wr_take) begin
            if (in_ch) begin
                case (ch_off)
                    `DMAM_CH_CTRL_A: begin
                        ctrl_a[ch_sel] <= wb_dat_i[7:0];
                    end
                    `DMAM_CH_CTRL_B: begin
                        ctrl_b[ch_sel] <= wb_dat_i[7:0];
                    end
                    `DMAM_CH_ADDR_CTRL: begin
                        addr_ctrl[ch_sel] <= wb_dat_i[7:0];
                    end
                    `DMAM_CH_TRIG_SEL: begin
                        trig_sel[ch_sel] <= wb_dat_i[7:0];
                    end
                    `DMAM_CH_CNT_LOW: begin
                        cnt_low[ch_sel] <= wb_dat_i[7:0];
                    end
                    `DMAM_CH_CNT_HIGH: begin
                        cnt_high[ch_sel] <= wb_dat_i[7:0];
                    end
                    `DMAM_CH_REPEAT: begin
                        rep_cnt[ch_sel] <= wb_dat_i[7:0];
                    end
                    // Reserved slots and address bytes are not stored here
                    default: begin
                    end
                endcase
            end else if (idx == `DMAM_IDX_CTRL) begin
                ctrl <= wb_dat_i[7:0];
            end else if (idx == `DMAM_IDX_EVT_MASK) begin
                evt_mask <= wb_dat_i[7:0];
            end
        end
    end

    // ======================================================================
    // Wrap events: sticky, write one to clear, a new event beats the clear
    // ======================================================================
    always @* begin
        next_status = evt_status;

        if (wr_take && !in_ch && idx == `DMAM_IDX_EVT_STATUS) begin
            next_status = evt_status & ~wb_dat_i[7:0];
        end

        // Set after clear: an event in the clearing cycle is kept
        next_status = next_status | {dst_wrap, src_wrap};
    end

    // Lowest pending channel wins the vector; both wraps of one channel
    // share its vector
    always @* begin
        pending     = next_status & evt_mask;
        next_vector = `DMAM_VEC_CH0;

        if (pending[0] | pending[4]) begin
            next_vector = `DMAM_VEC_CH0; // [RL6]
        end else if (pending[1] | pending[5]) begin
            next_vector = `DMAM_VEC_CH1; // [RL6]
        end else if (pending[2] | pending[6]) begin
            next_vector = `DMAM_VEC_CH2; // [RL6]
        end else if (pending[3] | pending[7]) begin
            next_vector = `DMAM_VEC_CH3; // [RL6]
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            evt_status   <= `DMAM_RST_BYTE;
            irq_o        <= 1'b0;
            irq_vector_o <= `DMAM_VEC_CH0;
        end else begin
            evt_status   <= next_status;
            // Built from the next status so irq moves with the flag
            irq_o        <= |(next_status & evt_mask);
            irq_vector_o <= next_vector;
        end
    end

    // ======================================================================
    // Registered address outputs toward the transfer bus
    // ======================================================================
    always @(posedge clk_i) begin
        if (rst_i) begin
            source_address_o      <= 96'h0;
            destination_address_o <= 96'h0;
        end else begin
            // Extra stage so the addresses leave straight from flops,
            // one cycle behind what the bus reads back
            source_address_o      <= src_addr;
            destination_address_o <= dst_addr;
        end
    end

endmodule // dmam_core
`default_nettype wire

// ---- dmam_core_bench.sv ----
// Self-checking bench for the DMA address map core
`default_nettype none
// ==========================================================================
// Bench top
// ==========================================================================
module dmam_core_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, start, busy;
    logic [8:0]  wb_adr_i;
    logic [3:0]  wb_sel_i, go, byte_moved_i;
    logic [7:0]  irq_vector_o, cnt;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [95:0] source_address_o, destination_address_o;
    int          fail_count, n_checks, seed, st, mk, ch, o, r, k;
    int          src[4], dst[4], ctl[4];

    dmam_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .byte_moved_i(byte_moved_i),
        .source_address_o(source_address_o), .destination_address_o(destination_address_o),
        .irq_o(irq_o), .irq_vector_o(irq_vector_o));
    dmam_mover u_mover (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .go_i(go),
        .cnt_i(cnt), .byte_moved_o(byte_moved_i), .busy_o(busy));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, seen);
            fail_count++;
        end
    endtask

    // One classic cycle; request held until ack is sampled high
    task automatic wb(input logic we, input int idx, input int d);
        int i;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {7'(idx), 2'b00};
        wb_dat_i <= {24'h0, 8'(d)};
        for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) @(posedge clk_i);
        if (i == 20) begin
            fail_count++;
            final_report();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic chk_ch(input int c);
        int b;
        wb(0, 16 * (c + 1) + 2, 0);
        chk("addr ctrl", rd, ctl[c]);
        for (b = 0; b < 3; b++) begin
            wb(0, 16 * (c + 1) + 8 + b, 0);
            chk("src byte", rd, (src[c] >> 8 * b) & 255);
            wb(0, 16 * (c + 1) + 12 + b, 0);
            chk("dst byte", rd, (dst[c] >> 8 * b) & 255);
        end
        chk("src out", 32'(source_address_o[24 * c +: 24]), src[c]);
        chk("dst out", 32'(destination_address_o[24 * c +: 24]), dst[c]);
    endtask

    task automatic step_model;
        int c, d;
        for (c = 0; c < 4; c++) begin
            if (go[c]) begin
                d = (ctl[c] >> 4) & 3;
                if ((d == 1 && src[c] == 'hFFFFFF) || (d == 2 && src[c] == 0)) st |= 1 << c;
                src[c] = (src[c] + (d == 1) - (d == 2)) & 'hFFFFFF;
                d = ctl[c] & 3;
                if ((d == 1 && dst[c] == 'hFFFFFF) || (d == 2 && dst[c] == 0)) st |= 16 << c;
                dst[c] = (dst[c] + (d == 1) - (d == 2)) & 'hFFFFFF;
            end
        end
    endtask

    task automatic chk_irq;
        int c, v;
        v = 0;
        for (c = 3; c >= 0; c--) if ((((st & mk) >> c) & 17) != 0) v = 2 * c;
        wb(0, 3, 0);
        chk("status", rd, st);
        chk("irq", 32'(irq_o), 32'((st & mk) != 0));
        chk("vector", 32'(irq_vector_o), v);
    endtask

    initial begin
        seed = 26001;
        fail_count = 0;
        n_checks = 0;
        st = 0;
        mk = 0;
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, start} = 4'h0;
        wb_adr_i = 9'h000;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        go = 4'h0;
        cnt = 8'h00;
        for (ch = 0; ch < 4; ch++) {src[ch], dst[ch], ctl[ch]} = '0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        // Writes to reserved and unmapped places must leave nothing behind
        for (ch = 0; ch < 4; ch++) for (o = 7; o < 16; o += 4) wb(1, 16 * (ch + 1) + o, 'hA5);
        wb(1, 'h7F, 'h5A);
        wb(0, 'h7F, 0);
        chk("unmapped", rd, 0);
        for (ch = 0; ch < 4; ch++) for (o = 0; o < 16; o++) begin
            wb(0, 16 * (ch + 1) + o, 0);
            chk("reset value", rd, (o == 4 || o == 5));
        end
        // Every direction code on every channel, addresses near both wrap points
        for (r = 0; r < 4; r++) begin
            mk = $random(seed) & 255;
            wb(1, 8, mk);
            for (ch = 0; ch < 4; ch++) begin
                ctl[ch] = (((r + ch) % 4) << 4) | ((r + ch + 1) % 4);
                src[ch] = ($random(seed) & 3) ^ (r[0] ? 0 : 'hFFFFFF);
                dst[ch] = ($random(seed) & 3) ^ (r[1] ? 'hFFFFFF : 0);
                wb(1, 16 * (ch + 1) + 2, ctl[ch]);
                for (k = 0; k < 3; k++) begin
                    wb(1, 16 * (ch + 1) + 8 + k, src[ch] >> 8 * k);
                    wb(1, 16 * (ch + 1) + 12 + k, dst[ch] >> 8 * k);
                end
            end
            @(posedge clk_i);
            start <= 1'b1;
            go    <= 4'($random(seed)) | 4'(1 << r);
            cnt   <= 8'(2 * r + 1);
            @(posedge clk_i);
            start <= 1'b0;
            for (k = 0; k < 200; k++) begin
                @(posedge clk_i);
                if (busy === 1'b0) break;
            end
            if (k == 200) begin
                fail_count++;
                final_report();
            end
            repeat (2 * r + 1) step_model();
            repeat (3) @(posedge clk_i);
            for (ch = 0; ch < 4; ch++) chk_ch(ch);
            chk_irq();
            // Partial clear first, then the rest
            wb(1, 3, st & 'h0F);
            st &= 'hF0;
            chk_irq();
            wb(1, 3, st);
            st = 0;
            chk_irq();
        end
        final_report();
    end
endmodule // dmam_core_bench
`default_nettype wire

// ---- dmam_mover.sv ----
// Transfer-side model: one byte move per selected channel, with random stalls
`default_nettype none
// ==========================================================================
// Mover
// ==========================================================================
module dmam_mover (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Burst request
    input  wire logic       start_i,
    input  wire logic [3:0] go_i,
    input  wire logic [7:0] cnt_i,
    // Byte moves
    output var logic  [3:0] byte_moved_o,
    output var logic        busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int left;
    int seed = 26001;
    // Stalls vary the spacing of moves; back-to-back moves also occur
    always @(posedge clk_i) begin
        byte_moved_o <= 4'h0;
        if (rst_i) begin
            left   <= 0;
            busy_o <= 1'b0;
        end else if (start_i) begin
            left   <= cnt_i;
            busy_o <= 1'b1;
        end else if (left > 0) begin
            if ($random(seed) & 1) begin
                byte_moved_o <= go_i;
                left         <= left - 1;
            end
        end else begin
            busy_o <= 1'b0;
        end
    end
endmodule // dmam_mover
`default_nettype wire

// ---- dmam_regs.vh ----
// Register indices, field positions, encodings and reset values of the DMA address map
`ifndef DMAM_REGS_VH
`define DMAM_REGS_VH

// ==========================================================================
// Widths
// ==========================================================================
`define DMAM_ADDR_W          24
`define DMAM_IDX_W           7
`define DMAM_NUM_CH          4

// ==========================================================================
// Controller register indices (byte address is four times the index)
// ==========================================================================
`define DMAM_IDX_CTRL        7'h00
`define DMAM_IDX_EVT_STATUS  7'h03
`define DMAM_IDX_EVT_MASK    7'h08

// ==========================================================================
// Channel block bases (indices)
// ==========================================================================
`define DMAM_IDX_CH0_BASE    7'h10
`define DMAM_IDX_CH1_BASE    7'h20
`define DMAM_IDX_CH2_BASE    7'h30
`define DMAM_IDX_CH3_BASE    7'h40
`define DMAM_IDX_CH_SPAN     7'h10

// ==========================================================================
// Channel offsets inside one sixteen-entry block
// ==========================================================================
`define DMAM_CH_CTRL_A       4'h0
`define DMAM_CH_CTRL_B       4'h1
`define DMAM_CH_ADDR_CTRL    4'h2
`define DMAM_CH_TRIG_SEL     4'h3
`define DMAM_CH_CNT_LOW      4'h4
`define DMAM_CH_CNT_HIGH     4'h5
`define DMAM_CH_REPEAT       4'h6
`define DMAM_CH_RSVD0        4'h7
`define DMAM_CH_SRC_B0       4'h8
`define DMAM_CH_SRC_B1       4'h9
`define DMAM_CH_SRC_B2       4'hA
`define DMAM_CH_RSVD1        4'hB
`define DMAM_CH_DST_B0       4'hC
`define DMAM_CH_DST_B1       4'hD
`define DMAM_CH_DST_B2       4'hE
`define DMAM_CH_RSVD2        4'hF

// ==========================================================================
// Address control fields and direction codes
// ==========================================================================
`define DMAM_SRC_DIR_HI      5
`define DMAM_SRC_DIR_LO      4
`define DMAM_DST_DIR_HI      1
`define DMAM_DST_DIR_LO      0
`define DMAM_DIR_FIXED       2'h0
`define DMAM_DIR_INC         2'h1
`define DMAM_DIR_DEC         2'h2

// ==========================================================================
// Interrupt vector word offsets per channel
// ==========================================================================
`define DMAM_VEC_CH0         8'h00
`define DMAM_VEC_CH1         8'h02
`define DMAM_VEC_CH2         8'h04
`define DMAM_VEC_CH3         8'h06

// ==========================================================================
// Reset values
// ==========================================================================
`define DMAM_RST_BYTE        8'h00
`define DMAM_RST_CNT         8'h01
`define DMAM_RST_ADDR        24'h000000

`endif
